// [design/rtcc_counters.sv]
`timescale 1ns/100ps
module rtcc_counters
  import rtcc_pkg::*;
#(
  parameter int TICK_CYCLES_P = rtcc_pkg::TICK_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire rtcc_pkg::rtcc_req_t reg_req,
  input  wire logic              access_busy,
  input  wire logic              supply_low_pin,
  input  wire logic              osc_stop_pin,
  output logic [7:0]             rd_data_q,
  output logic                   supply_low_flag_q
);
  import rtcc_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES_P);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rtcc_time_t    t_q;
  rtcc_time_t    t_d;
  logic [CW-1:0] div_q;
  logic          tick_q;
  logic          pend_q;
  logic          step;
  logic          low_s;
  logic          stop_s;
  logic          wr_sec;
  logic [7:0]    last_day;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  rtcc_sync3 #(.RST_VAL(1'b0)) u_sync_low (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     (supply_low_pin),
    .dout_q  (low_s)
  );

  rtcc_sync3 #(.RST_VAL(1'b0)) u_sync_stop (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     (osc_stop_pin),
    .dout_q  (stop_s)
  );

  // ---------------------------------------------------------------
  // one second enable
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == CW'(TICK_CYCLES_P - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= CW'(div_q + 1'b1);
      tick_q <= 1'b0;
    end
  end

  // hold one missed tick while the host is busy
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (access_busy && tick_q) begin
      pend_q <= 1'b1;
    end else if (!access_busy) begin
      pend_q <= 1'b0;
    end
  end

  assign step = !access_busy && (tick_q || pend_q);

  // ---------------------------------------------------------------
  // month length, leap february
  // ---------------------------------------------------------------
  always_comb begin
    logic leap;
    leap = (!t_q.yr_t[0] && (t_q.yr_u == 4'h0 || t_q.yr_u == 4'h4 || t_q.yr_u == 4'h8)) ||
           (t_q.yr_t[0] && (t_q.yr_u == 4'h2 || t_q.yr_u == 4'h6));
    case ({3'b000, t_q.mon_t, t_q.mon_u})
      8'h02:   last_day = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // ---------------------------------------------------------------
  // carry chain for one second
  // ---------------------------------------------------------------
  always_comb begin
    logic c;
    t_d = t_q;
    c   = 1'b0;
    // seconds
    if (t_q.sec_u == UNIT_MAX) begin
      t_d.sec_u = 4'h0;
      if ({1'b0, t_q.sec_t} == MINSEC_TMAX) begin
        t_d.sec_t = 3'h0;
        c         = 1'b1;
      end else begin
        t_d.sec_t = 3'(t_q.sec_t + 3'h1);
      end
    end else begin
      t_d.sec_u = 4'(t_q.sec_u + 4'h1);
    end
    // minutes
    if (c) begin
      c = 1'b0;
      if (t_q.min_u == UNIT_MAX) begin
        t_d.min_u = 4'h0;
        if ({1'b0, t_q.min_t} == MINSEC_TMAX) begin
          t_d.min_t = 3'h0;
          c         = 1'b1;
        end else begin
          t_d.min_t = 3'(t_q.min_t + 3'h1);
        end
      end else begin
        t_d.min_u = 4'(t_q.min_u + 4'h1);
      end
    end
    // hours, 24 hour wrap
    if (c) begin
      c = 1'b0;
      if ({2'b00, t_q.hr_t, t_q.hr_u} == HOUR_LAST) begin
        t_d.hr_t = 2'h0;
        t_d.hr_u = 4'h0;
        c        = 1'b1;
      end else if (t_q.hr_u == UNIT_MAX) begin
        t_d.hr_u = 4'h0;
        t_d.hr_t = 2'(t_q.hr_t + 2'h1);
      end else begin
        t_d.hr_u = 4'(t_q.hr_u + 4'h1);
      end
    end
    // day of month and weekday
    if (c) begin
      c = 1'b0;
      t_d.wday = (t_q.wday >= WDAY_LAST) ? 3'h0 : 3'(t_q.wday + 3'h1);
      if ({2'b00, t_q.day_t, t_q.day_u} >= last_day) begin
        t_d.day_t = 2'h0;
        t_d.day_u = 4'h1;
        c         = 1'b1;
      end else if (t_q.day_u == UNIT_MAX) begin
        t_d.day_u = 4'h0;
        t_d.day_t = 2'(t_q.day_t + 2'h1);
      end else begin
        t_d.day_u = 4'(t_q.day_u + 4'h1);
      end
    end
    // month
    if (c) begin
      c = 1'b0;
      if ({3'b000, t_q.mon_t, t_q.mon_u} >= MONTH_LAST) begin
        t_d.mon_t = 1'b0;
        t_d.mon_u = 4'h1;
        c         = 1'b1;
      end else if (t_q.mon_u == UNIT_MAX) begin
        t_d.mon_t = 1'b1;
        t_d.mon_u = 4'h0;
      end else begin
        t_d.mon_u = 4'(t_q.mon_u + 4'h1);
      end
    end
    // year and century
    if (c) begin
      if ({t_q.yr_t, t_q.yr_u} == YEAR_LAST) begin
        t_d.yr_t    = 4'h0;
        t_d.yr_u    = 4'h0;
        t_d.century = !t_q.century;
      end else if (t_q.yr_u == UNIT_MAX) begin
        t_d.yr_u = 4'h0;
        t_d.yr_t = 4'(t_q.yr_t + 4'h1);
      end else begin
        t_d.yr_u = 4'(t_q.yr_u + 4'h1);
      end
    end
  end

  // ---------------------------------------------------------------
  // time registers: host write wins, else step on tick
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      t_q <= TIME_RST;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_SEC: begin
          t_q.sec_t <= reg_req.wdata[6:4];
          t_q.sec_u <= reg_req.wdata[3:0];
        end
        ADDR_MIN: begin
          t_q.min_t <= reg_req.wdata[6:4];
          t_q.min_u <= reg_req.wdata[3:0];
        end
        ADDR_HOUR: begin
          t_q.hr_t <= reg_req.wdata[5:4];
          t_q.hr_u <= reg_req.wdata[3:0];
        end
        ADDR_DAY: begin
          t_q.day_t <= reg_req.wdata[5:4];
          t_q.day_u <= reg_req.wdata[3:0];
        end
        ADDR_WDAY: begin
          t_q.wday <= reg_req.wdata[2:0];
        end
        ADDR_MONTH: begin
          t_q.century <= reg_req.wdata[CENTURY_BIT];
          t_q.mon_t   <= reg_req.wdata[4];
          t_q.mon_u   <= reg_req.wdata[3:0];
        end
        ADDR_YEAR: begin
          t_q.yr_t <= reg_req.wdata[7:4];
          t_q.yr_u <= reg_req.wdata[3:0];
        end
        default: begin
          t_q <= t_q;
        end
      endcase
    end else if (step) begin
      t_q <= t_d;
    end
  end

  // ---------------------------------------------------------------
  // supply-low integrity flag, set beats clear
  // ---------------------------------------------------------------
  assign wr_sec = reg_req.wr && (reg_req.addr == ADDR_SEC);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      supply_low_flag_q <= FLAG_RST;
    end else if (low_s || stop_s) begin
      supply_low_flag_q <= 1'b1;
    end else if (wr_sec) begin
      supply_low_flag_q <= reg_req.wdata[FLAG_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read mux, unused bits zero
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_q <= 8'h00;
    end else begin
      case (reg_req.addr)
        ADDR_SEC:   rd_data_q <= {supply_low_flag_q, t_q.sec_t, t_q.sec_u};
        ADDR_MIN:   rd_data_q <= {1'b0, t_q.min_t, t_q.min_u};
        ADDR_HOUR:  rd_data_q <= {2'b00, t_q.hr_t, t_q.hr_u};
        ADDR_DAY:   rd_data_q <= {2'b00, t_q.day_t, t_q.day_u};
        ADDR_WDAY:  rd_data_q <= {5'b00000, t_q.wday};
        ADDR_MONTH: rd_data_q <= {t_q.century, 2'b00, t_q.mon_t, t_q.mon_u};
        ADDR_YEAR:  rd_data_q <= {t_q.yr_t, t_q.yr_u};
        default:    rd_data_q <= 8'h00;
      endcase
    end
  end
endmodule

// [design/rtcc_pkg.sv]
package rtcc_pkg;

  // ---------------------------------------------------------------
  // register word addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SEC   = 8'h02;
  localparam logic [7:0] ADDR_MIN   = 8'h03;
  localparam logic [7:0] ADDR_HOUR  = 8'h04;
  localparam logic [7:0] ADDR_DAY   = 8'h05;
  localparam logic [7:0] ADDR_WDAY  = 8'h06;
  localparam logic [7:0] ADDR_MONTH = 8'h07;
  localparam logic [7:0] ADDR_YEAR  = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLAG_BIT    = 7;  // supply-low flag in seconds register
  localparam int CENTURY_BIT = 7;  // century bit in month register

  // ---------------------------------------------------------------
  // limits of the counters, in bcd
  // ---------------------------------------------------------------
  localparam logic [3:0] UNIT_MAX   = 4'h9;
  localparam logic [3:0] MINSEC_TMAX = 4'h5;
  localparam logic [7:0] HOUR_LAST  = 8'h23;
  localparam logic [2:0] WDAY_LAST  = 3'h6;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST  = 8'h99;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ  = 40_000_000;
  localparam int TICK_HZ     = 1;
  localparam int TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sec_t;
    logic [3:0] sec_u;
    logic [2:0] min_t;
    logic [3:0] min_u;
    logic [1:0] hr_t;
    logic [3:0] hr_u;
    logic [1:0] day_t;
    logic [3:0] day_u;
    logic [2:0] wday;
    logic       mon_t;
    logic [3:0] mon_u;
    logic       century;
    logic [3:0] yr_t;
    logic [3:0] yr_u;
  } rtcc_time_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } rtcc_req_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam rtcc_time_t TIME_RST = '{sec_t: 3'h0, sec_u: 4'h0, min_t: 3'h0, min_u: 4'h0,
                                      hr_t: 2'h0, hr_u: 4'h0, day_t: 2'h0, day_u: 4'h1,
                                      wday: 3'h0, mon_t: 1'b0, mon_u: 4'h1, century: 1'b0,
                                      yr_t: 4'h0, yr_u: 4'h0};
  localparam logic       FLAG_RST = 1'b1;

endpackage

// [design/rtcc_sync3.sv]
`timescale 1ns/100ps
module rtcc_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // three stage chain, first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dout_q <= RST_VAL;
    end else if (s2_q == s3_q) begin
      dout_q <= s3_q;
    end
  end
endmodule

// [verification/rtcc_counters_assertions.sv]
`timescale 1ns/100ps
module rtcc_counters_assertions #(
  parameter int TICK_CYCLES_P = 16
) (
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire rtcc_pkg::rtcc_req_t reg_req,
  input wire logic                access_busy,
  input wire logic                supply_low_pin,
  input wire logic                osc_stop_pin,
  input wire logic [7:0]          rd_data_q,
  input wire logic                supply_low_flag_q
);
  import rtcc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // integrity flag and register reads
  // ---------------------------------------------------------------
  sequence quiet_s; (!supply_low_pin && !osc_stop_pin) [*6]; endsequence
  sequence clear_s; reg_req.wr && reg_req.addr == ADDR_SEC && !reg_req.wdata[FLAG_BIT]; endsequence
  property rd_zero_p(a, m); $past(reg_req.addr) == a |-> (rd_data_q & m) == 8'h00; endproperty
  flag_reset_a: assert property ($fell(srst) |-> supply_low_flag_q) else $error("flag low after reset");
  flag_sticks_a: assert property (supply_low_flag_q && !(reg_req.wr && reg_req.addr == ADDR_SEC)
    |=> supply_low_flag_q) else $error("flag dropped");
  flag_clear_a: assert property (quiet_s ##0 clear_s |=> !supply_low_flag_q) else $error("no clear");
  low_sets_a: assert property (supply_low_pin [*6] |-> supply_low_flag_q) else $error("low not set");
  osc_sets_a: assert property (osc_stop_pin [*6] |-> supply_low_flag_q) else $error("stop not set");
  sec_bcd_a: assert property ($past(reg_req.addr) == ADDR_SEC |-> rd_data_q[6:4] <= 3'h5
    && rd_data_q[3:0] <= 4'h9) else $error("seconds not bcd");
  min_unused_a: assert property (rd_zero_p(ADDR_MIN, 8'h80)) else $error("minutes bit 7");
  hour_unused_a: assert property (rd_zero_p(ADDR_HOUR, 8'hC0)) else $error("hours bits");
  day_unused_a: assert property (rd_zero_p(ADDR_DAY, 8'hC0)) else $error("day bits");
  wday_unused_a: assert property (rd_zero_p(ADDR_WDAY, 8'hF8)) else $error("weekday bits");
  month_unused_a: assert property (rd_zero_p(ADDR_MONTH, 8'h60)) else $error("month bits");
  unmapped_zero_a: assert property ($past(reg_req.addr) > ADDR_YEAR || $past(reg_req.addr) < ADDR_SEC
    |-> rd_data_q == 8'h00) else $error("unmapped read");
  busy_frozen_a: assert property (!$past(srst) && !$past(srst, 2) && $past(access_busy) && $past(access_busy, 2)
    && $past(access_busy, 3) && !$past(reg_req.wr) && !$past(reg_req.wr, 2) && $past(reg_req.addr) != ADDR_SEC
    && $past(reg_req.addr) == $past(reg_req.addr, 2) |-> $stable(rd_data_q)) else $error("moved in access");
endmodule
bind rtcc_counters rtcc_counters_assertions #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.sys_clk(sys_clk),
  .srst(srst), .reg_req(reg_req), .access_busy(access_busy), .supply_low_pin(supply_low_pin),
  .osc_stop_pin(osc_stop_pin), .rd_data_q(rd_data_q), .supply_low_flag_q(supply_low_flag_q));

// [verification/rtcc_host_model.sv]
`timescale 1ns/100ps
module rtcc_host_model (
  input  wire logic           sys_clk,
  input  wire logic [7:0]     rd_data_q,
  output rtcc_pkg::rtcc_req_t req,
  output logic                busy
);
  import rtcc_pkg::*;
  // idle bus at time zero
  initial begin
    req  = '0;
    busy = 1'b0;
  end
  // move to the drive point n edges on
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one byte per edge; wr stays up for back to back bytes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wr: 1'b1, wdata: d};
    step(1);
  endtask
  // end of a write burst; stale data inverted
  task automatic idle();
    req.wr    = 1'b0;
    req.wdata = ~req.wdata;
  endtask
  // address held two edges, data taken after the second
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.addr = a;
    step(2);
    d = rd_data_q;
  endtask
  // access window around a burst
  task automatic hold(input logic b);
    busy = b;
  endtask
endmodule

// [verification/rtcc_counters_tb.sv]
`timescale 1ns/100ps
module rtcc_counters_tb;
  import rtcc_pkg::*;
  localparam int TICKS = 16;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        supply_low_pin = 1'b0;
  logic        osc_stop_pin = 1'b0;
  logic        access_busy;
  logic        supply_low_flag_q;
  logic [7:0]  rd_data_q;
  logic [7:0]  v;
  rtcc_req_t   reg_req;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;
  // bytes written, seconds first, and the bytes after one step
  logic [55:0] wv [8] = '{56'h5959_2331_0612_99, 56'h5959_2328_0302_04, 56'h5959_2328_0302_01,
    56'h5959_2329_0202_00, 56'h5959_2330_0104_05, 56'h0985_D3C5_FA69_47, 56'h5959_0915_0585_12,
    56'h5959_2331_0092_99};
  logic [55:0] ev [8] = '{56'h0000_0001_0081_00, 56'h0000_0029_0402_04, 56'h0000_0001_0403_01,
    56'h0000_0001_0303_00, 56'h0000_0001_0205_05, 56'h1005_1305_0209_47, 56'h0000_1015_0585_12,
    56'h0000_0001_0101_00};
  rtcc_counters #(.TICK_CYCLES_P(TICKS)) DUT (.sys_clk(sys_clk), .srst(srst), .reg_req(reg_req),
    .access_busy(access_busy), .supply_low_pin(supply_low_pin), .osc_stop_pin(osc_stop_pin),
    .rd_data_q(rd_data_q), .supply_low_flag_q(supply_low_flag_q));
  rtcc_host_model host (.sys_clk(sys_clk), .rd_data_q(rd_data_q), .req(reg_req), .busy(access_busy));
  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // wait for a seconds step to learn the tick phase
  task automatic sync();
    logic [7:0] a;
    host.rd(ADDR_SEC, a);
    for (int i = 0; i < 40 && rd_data_q === a; i++) begin
      host.step(1);
    end
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    host.step(16);
    srst = 1'b0;
    // rows: write all, hold over two ticks, one step, read back frozen
    for (int i = 0; i < 8; i++) begin
      sync();
      host.hold(1'b1);
      for (int k = 0; k < 7; k++) begin
        host.wr(ADDR_SEC + 8'(k), wv[i][55-8*k -: 8]);
      end
      host.idle();
      host.step(31);
      host.hold(1'b0);
      host.step(2);
      host.hold(1'b1);
      for (int k = 0; k < 7; k++) begin
        host.rd(ADDR_SEC + 8'(k), v);
        chk("time reg", ev[i][55-8*k -: 8], v);
      end
      host.hold(1'b0);
    end
    host.hold(1'b1);
    // detector report sets the flag, which outlives the report
    supply_low_pin = 1'b1;
    host.step(6);
    supply_low_pin = 1'b0;
    host.step(8);
    chk("flag", 8'h01, {7'h00, supply_low_flag_q});
    host.wr(ADDR_SEC, 8'h00);
    host.idle();
    host.step(2);
    chk("flag", 8'h00, {7'h00, supply_low_flag_q});
    // stopped oscillator sets seconds bit 7
    osc_stop_pin = 1'b1;
    host.step(6);
    osc_stop_pin = 1'b0;
    host.step(8);
    host.rd(ADDR_SEC, v);
    chk("sec bit 7", 8'h80, v & 8'h80);
    // unmapped place ignores writes
    host.wr(8'h20, 8'h5A);
    host.idle();
    host.rd(8'h20, v);
    chk("unmapped", 8'h00, v);
    // reset in mid-run
    srst = 1'b1;
    host.step(2);
    srst = 1'b0;
    host.rd(ADDR_SEC, v);
    chk("sec after reset", 8'h80, v);
    host.rd(ADDR_MONTH, v);
    chk("month after reset", 8'h01, v);
    report_and_stop();
  end
endmodule
